// ### hw/ddcov_top.sv
// down-converter gain stage, over-range detector, stretched flag pins and apb register file
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ddcov_map.svh"

// Behaviour
// - gain bit selects 0 dB or 6.02 dB
// - I control bit when level reaches threshold
// - Q control bit when level reaches threshold
// - threshold scaled so 256 is full scale
// - pin enable low holds four pins low
// - enable touches pins only, never control bits
// - pins stay high 8 times 2^N cycles
module ddcov_top #(
    parameter int SAMPLE_W = 16,
    parameter int ADDR_W   = 12
) (
    // clock, reset, enable
    input  wire logic                              clk_sys,
    input  wire logic                              srst,
    input  wire logic                              ce,
    // apb slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [ADDR_W-1:0]                 paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // down-converter samples in, channel 0 = a, 1 = b
    input  wire logic [1:0]                        in_valid,
    input  wire logic [1:0][SAMPLE_W-1:0]          in_i,
    input  wire logic [1:0][SAMPLE_W-1:0]          in_q,
    // gained samples out with control bits
    output logic      [1:0]                        out_valid,
    output logic      [1:0][SAMPLE_W-1:0]          out_i,
    output logic      [1:0][SAMPLE_W-1:0]          out_q,
    output ddcov_pkg::ddcov_ctrl_t [1:0]           out_ctrl,
    // over-range status pins
    output logic                                   chan_a_flag_pin_0,
    output logic                                   chan_a_flag_pin_1,
    output logic                                   chan_b_flag_pin_0,
    output logic                                   chan_b_flag_pin_1,
    // interrupt
    output logic                                   irq
);
    // ******************************************
    // elaboration checks
    // ******************************************
    generate
        if (SAMPLE_W < 9 || SAMPLE_W > 32) begin : g_bad_w
            $error("SAMPLE_W must lie in 9..32");
        end
        if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_a
            $error("ADDR_W must lie in 12..32");
        end
    endgenerate

    // ******************************************
    // apb register file
    // ******************************************
    ddcov_pkg::ddcov_cfg_t cfg_reg, cfg_next;
    logic [3:0]            status_reg, status_next;
    logic [3:0]            mask_reg, mask_next;
    logic [31:0]           prdata_reg, prdata_next;
    logic [3:0]            det;
    logic                  hit, wr_en;
    logic [9:0]            idx;

    assign idx    = paddr[11:2];
    // the slave never stalls except while the block is frozen
    assign pready = ce;
    assign wr_en  = ce & psel & penable & pwrite;
    assign prdata = prdata_reg;
    assign pslverr = psel & penable & ~hit;
    assign irq    = |(status_reg & mask_reg);

    // address decode and next register values
    always_comb begin
        cfg_next    = cfg_reg;
        mask_next   = mask_reg;
        prdata_next = prdata_reg;
        hit         = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0) &&
                      (idx == `DDCOV_IDX_GAIN_CFG || idx == `DDCOV_IDX_THR_I ||
                       idx == `DDCOV_IDX_THR_Q || idx == `DDCOV_IDX_PIN_CFG ||
                       idx == `DDCOV_IDX_IRQ_STATUS || idx == `DDCOV_IDX_IRQ_MASK);
        // read data is captured in the setup cycle so it leaves a flop
        if (psel && !penable) begin
            prdata_next = 32'h0000_0000;
            if (hit) begin
                unique case (idx)
                    `DDCOV_IDX_GAIN_CFG:   prdata_next[`DDCOV_GAIN_DOUBLE_BIT] = cfg_reg.gain_double;
                    `DDCOV_IDX_THR_I:      prdata_next[7:0] = cfg_reg.threshold_i_level;
                    `DDCOV_IDX_THR_Q:      prdata_next[7:0] = cfg_reg.threshold_q_level;
                    `DDCOV_IDX_PIN_CFG: begin
                        prdata_next[`DDCOV_PIN_ENABLE_BIT] = cfg_reg.status_pin_enable;
                        prdata_next[`DDCOV_EXP_MSB:`DDCOV_EXP_LSB] = cfg_reg.pulse_extension_exponent;
                    end
                    `DDCOV_IDX_IRQ_STATUS: prdata_next[3:0] = status_reg;
                    default:               prdata_next[3:0] = mask_reg;
                endcase
            end
        end
        // ddc_gain_double is software's call; no guard against clipping here
        if (wr_en && hit) begin
            if (idx == `DDCOV_IDX_GAIN_CFG) begin
                cfg_next.gain_double = pwdata[`DDCOV_GAIN_DOUBLE_BIT];
            end
            if (idx == `DDCOV_IDX_THR_I) begin
                cfg_next.threshold_i_level = pwdata[7:0];
            end
            if (idx == `DDCOV_IDX_THR_Q) begin
                cfg_next.threshold_q_level = pwdata[7:0];
            end
            if (idx == `DDCOV_IDX_PIN_CFG) begin
                cfg_next.status_pin_enable        = pwdata[`DDCOV_PIN_ENABLE_BIT];
                cfg_next.pulse_extension_exponent = pwdata[`DDCOV_EXP_MSB:`DDCOV_EXP_LSB];
            end
            if (idx == `DDCOV_IDX_IRQ_MASK) begin
                mask_next = pwdata[3:0];
            end
        end
        // write one to clear; a detection in the same cycle wins
        status_next = status_reg;
        if (wr_en && hit && idx == `DDCOV_IDX_IRQ_STATUS) begin
            status_next = status_next & ~pwdata[3:0];
        end
        status_next = status_next | det;
    end

    // register file flops
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_reg.gain_double              <= 1'(`DDCOV_RST_GAIN_CFG >> `DDCOV_GAIN_DOUBLE_BIT);
            cfg_reg.threshold_i_level        <= `DDCOV_RST_THR_I;
            cfg_reg.threshold_q_level        <= `DDCOV_RST_THR_Q;
            cfg_reg.status_pin_enable        <= 1'(`DDCOV_RST_PIN_CFG >> `DDCOV_PIN_ENABLE_BIT);
            cfg_reg.pulse_extension_exponent <= 3'(`DDCOV_RST_PIN_CFG >> `DDCOV_EXP_LSB);
            status_reg                       <= `DDCOV_RST_IRQ;
            mask_reg                         <= `DDCOV_RST_IRQ;
            prdata_reg                       <= 32'h0000_0000;
        end else if (ce) begin
            cfg_reg    <= cfg_next;
            status_reg <= status_next;
            mask_reg   <= mask_next;
            prdata_reg <= prdata_next;
        end
    end

    // ******************************************
    // gain and detection per channel
    // ******************************************
    logic [1:0]                        valid_next;
    logic [1:0][SAMPLE_W-1:0]          i_next, q_next;
    ddcov_pkg::ddcov_ctrl_t [1:0]      ctrl_next;
    logic [SAMPLE_W-1:0]               thr_i_scaled, thr_q_scaled;

    // threshold T sits at T/256 of full scale
    assign thr_i_scaled = SAMPLE_W'(cfg_reg.threshold_i_level) << (SAMPLE_W - 9);
    assign thr_q_scaled = SAMPLE_W'(cfg_reg.threshold_q_level) << (SAMPLE_W - 9);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [SAMPLE_W-1:0] gi, gq, mag_i, mag_q;
            always_comb begin
                gi = in_i[ch];
                gq = in_q[ch];
                if (cfg_reg.gain_double) begin
                    gi = (in_i[ch][SAMPLE_W-1] != in_i[ch][SAMPLE_W-2]) ?
                         {in_i[ch][SAMPLE_W-1], {(SAMPLE_W-1){~in_i[ch][SAMPLE_W-1]}}} :
                         {in_i[ch][SAMPLE_W-2:0], 1'b0};
                    gq = (in_q[ch][SAMPLE_W-1] != in_q[ch][SAMPLE_W-2]) ?
                         {in_q[ch][SAMPLE_W-1], {(SAMPLE_W-1){~in_q[ch][SAMPLE_W-1]}}} :
                         {in_q[ch][SAMPLE_W-2:0], 1'b0};
                end
                // most negative code maps to full scale, which is unsigned 2^(w-1)
                mag_i = gi[SAMPLE_W-1] ? SAMPLE_W'(-gi) : gi;
                mag_q = gq[SAMPLE_W-1] ? SAMPLE_W'(-gq) : gq;
                valid_next[ch] = in_valid[ch];
                i_next[ch]     = gi;
                q_next[ch]     = gq;
                // i control bit on reaching the first threshold
                ctrl_next[ch].i_over = mag_i >= thr_i_scaled;
                // q control bit on reaching the second threshold
                ctrl_next[ch].q_over = mag_q >= thr_q_scaled;
            end
            // detections feed irq status bits and stretch counters whatever the pin enable
            assign det[2*ch]   = ce & in_valid[ch] & ctrl_next[ch].i_over;
            assign det[2*ch+1] = ce & in_valid[ch] & ctrl_next[ch].q_over;
        end
    endgenerate

    // sample output flops; data holds between valid samples
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_valid <= 2'h0;
            out_i     <= '0;
            out_q     <= '0;
            out_ctrl  <= '0;
        end else if (ce) begin
            out_valid <= valid_next;
            for (int c = 0; c < 2; c++) begin
                if (valid_next[c]) begin
                    out_i[c]    <= i_next[c];
                    out_q[c]    <= q_next[c];
                    out_ctrl[c] <= ctrl_next[c];
                end
            end
        end
    end

    // ******************************************
    // pulse stretch of the status pins
    // ******************************************
    logic [10:0]      stretch_len;
    logic [3:0][10:0] cnt_reg, cnt_next;
    logic [3:0]       pin_reg, pin_next;

    // stretch length 8 * 2^n, up to 1024 cycles
    assign stretch_len = `DDCOV_STRETCH_BASE << cfg_reg.pulse_extension_exponent;

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_pin
            always_comb begin
                // any detection reloads the full stretch
                if (det[p]) begin
                    cnt_next[p] = stretch_len;
                end else if (cnt_reg[p] != 11'h000) begin
                    cnt_next[p] = cnt_reg[p] - 11'h001;
                end else begin
                    cnt_next[p] = 11'h000;
                end
                // pins forced low while the enable is clear
                pin_next[p] = cfg_reg.status_pin_enable & (cnt_next[p] != 11'h000);
            end
        end
    endgenerate

    // counters keep running with the enable low, so an event shortly before the enable is set shows only the rest of its stretch
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_reg <= '0;
            pin_reg <= 4'h0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            pin_reg <= pin_next;
        end
    end

    assign chan_a_flag_pin_0 = pin_reg[0];
    assign chan_a_flag_pin_1 = pin_reg[1];
    assign chan_b_flag_pin_0 = pin_reg[2];
    assign chan_b_flag_pin_1 = pin_reg[3];

    // ******************************************
    // assertions and covers
    // ******************************************
    logic [10:0] high_cnt;
    // cycles pin 0 has been high, for the minimum width check
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            high_cnt <= 11'h000;
        end else if (ce) begin
            high_cnt <= pin_reg[0] ? high_cnt + 11'h001 : 11'h000;
        end
    end

    gain_unity_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && in_valid[0] && !cfg_reg.gain_double |=> out_i[0] == $past(in_i[0]))
        else $error("unity gain altered sample");
    gain_double_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && in_valid[0] && cfg_reg.gain_double && in_q[0][SAMPLE_W-1] == in_q[0][SAMPLE_W-2]
        |=> out_q[0] == {$past(in_q[0][SAMPLE_W-2:0]), 1'b0})
        else $error("doubled gain wrong");
    thr_reset_a: assert property (@(posedge clk_sys)
        srst |=> cfg_reg.threshold_i_level == 8'hf2 && cfg_reg.threshold_q_level == 8'hab)
        else $error("threshold reset value wrong");
    flag_full_i_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && in_valid[1] && !cfg_reg.gain_double && in_i[1] == {1'b1, {(SAMPLE_W-1){1'b0}}}
        |=> out_ctrl[1].i_over)
        else $error("full scale sample not flagged");
    flag_low_q_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && in_valid[0] && !cfg_reg.gain_double && in_q[0] == '0 && cfg_reg.threshold_q_level != 8'h00
        |=> !out_ctrl[0].q_over)
        else $error("zero sample flagged");
    pins_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !cfg_reg.status_pin_enable |=> pin_reg == 4'h0)
        else $error("pin driven while disabled");
    ctrl_ignores_en_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !cfg_reg.status_pin_enable && det[0] |=> out_ctrl[0].i_over)
        else $error("control bit gated by pin enable");
    pin_width_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && pin_reg[0] && !pin_next[0] && cfg_reg.status_pin_enable && $stable(stretch_len)
        |-> high_cnt + 11'h001 >= stretch_len)
        else $error("pin pulse shorter than stretch");
    retrigger_a: assert property (@(posedge clk_sys) disable iff (srst)
        det[3] && cfg_reg.status_pin_enable |=> pin_reg[3] && cnt_reg[3] == $past(stretch_len))
        else $error("detection did not reload stretch");

    stretch_cov_c: cover property (@(posedge clk_sys) disable iff (srst) $fell(pin_reg[0]));
    retrig_cov_c: cover property (@(posedge clk_sys) disable iff (srst) pin_reg[3] && det[3]);
    irq_cov_c: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));
endmodule

// ### pkg/ddcov_map.svh
// register indices, field positions, reset values and timing counts of the gain and over-range block
`ifndef DDCOV_MAP_SVH
`define DDCOV_MAP_SVH

// register indices; byte address is four times the index
`define DDCOV_IDX_GAIN_CFG     10'h210
`define DDCOV_IDX_THR_I        10'h211
`define DDCOV_IDX_THR_Q        10'h212
`define DDCOV_IDX_PIN_CFG      10'h213
`define DDCOV_IDX_IRQ_STATUS   10'h218
`define DDCOV_IDX_IRQ_MASK     10'h219

// field positions
`define DDCOV_GAIN_DOUBLE_BIT  0
`define DDCOV_PIN_ENABLE_BIT   3
`define DDCOV_EXP_MSB          2
`define DDCOV_EXP_LSB          0

// reset values
`define DDCOV_RST_GAIN_CFG     8'h00
`define DDCOV_RST_THR_I        8'hf2
`define DDCOV_RST_THR_Q        8'hab
`define DDCOV_RST_PIN_CFG      8'h07
`define DDCOV_RST_IRQ          4'h0

// timing: base stretch length in sample clock cycles, scaled by 2^exponent
`define DDCOV_STRETCH_BASE     11'h008

`endif

// ### pkg/ddcov_pkg.sv
// types shared by the gain and over-range block
package ddcov_pkg;
    // per-sample control bits carried beside the down-converter output
    typedef struct packed {
        logic q_over;
        logic i_over;
    } ddcov_ctrl_t;

    // decoded configuration held in the register file
    typedef struct packed {
        logic       gain_double;
        logic [7:0] threshold_i_level;
        logic [7:0] threshold_q_level;
        logic       status_pin_enable;
        logic [2:0] pulse_extension_exponent;
    } ddcov_cfg_t;
endpackage

// ### sim/ddcov_pin_monitor.sv
// host-side monitor that measures the high time of each over-range pin
`timescale 1ns/1ps
module ddcov_pin_monitor (
    // clock
    input  wire logic             clk_sys,
    // pins: bit 0 a-I, 1 a-Q, 2 b-I, 3 b-Q
    input  wire logic [3:0]       pins,
    // last measured width and pulse count of each pin
    output logic      [3:0][15:0] width,
    output logic      [3:0][7:0]  pulses
);
    logic [3:0][15:0] run;

    // start from empty counts so the first pulse is measured cleanly
    initial begin
        run = '0;
        width = '0;
        pulses = '0;
    end

    // stretch width count
    // an unknown pin level is not counted, so it shows up as a short pulse
    always @(posedge clk_sys) begin
        for (int p = 0; p < 4; p++) begin
            if (pins[p] === 1'b1) begin
                run[p] <= run[p] + 16'h0001;
            end else if (run[p] != 16'h0000) begin
                width[p] <= run[p];
                pulses[p] <= pulses[p] + 8'h01;
                run[p] <= 16'h0000;
            end
        end
    end
endmodule

// ### sim/ddcov_top_test.sv
// self-checking bench for the gain and over-range block
`timescale 1ns/1ps
module ddcov_top_test;
    logic                         clk_sys, srst, ce, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0]                  paddr;
    logic [31:0]                  pwdata, prdata, rd, v;
    logic [1:0]                   in_valid, out_valid;
    logic [1:0][15:0]             in_i, in_q, out_i, out_q, si, sq;
    ddcov_pkg::ddcov_ctrl_t [1:0] out_ctrl;
    wire  [3:0]                   pins;
    logic [3:0][15:0]             width;
    logic [3:0][7:0]              pulses;
    logic [7:0]                   thr_i, thr_q;
    logic                         gain;
    int                           miscompares, checked;
    logic [11:0]                  addrs [6] = '{12'h840, 12'h844, 12'h848, 12'h84c, 12'h860, 12'h864};
    logic [7:0]                   rstv [6] = '{8'h00, 8'hf2, 8'hab, 8'h07, 8'h00, 8'h00};
    logic [7:0]                   msk [4] = '{8'h01, 8'hff, 8'hff, 8'h0f};

    ddcov_top ddcov_top_i (.clk_sys(clk_sys), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
        .out_i(out_i), .out_q(out_q), .out_ctrl(out_ctrl), .chan_a_flag_pin_0(pins[0]),
        .chan_a_flag_pin_1(pins[1]), .chan_b_flag_pin_0(pins[2]), .chan_b_flag_pin_1(pins[3]), .irq(irq));
    ddcov_pin_monitor ddcov_pin_monitor_i (.clk_sys(clk_sys), .pins(pins), .width(width), .pulses(pulses));

    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************
    // tasks and models
    // ****************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one apb transfer; no wait count is assumed, only the watchdog cuts a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // saturating gain stage as software expects it
    function automatic logic [15:0] gained(input logic [15:0] x, input logic g);
        int s;
        s = $signed(x);
        s = g ? s * 2 : s;
        s = (s > 32767) ? 32767 : ((s < -32768) ? -32768 : s);
        return s[15:0];
    endfunction

    // full scale is 256 threshold steps, so one step is 128 lsb of a 16-bit sample
    function automatic logic over(input logic [15:0] y, input logic [7:0] t);
        int s;
        s = $signed(y);
        s = (s < 0) ? -s : s;
        return s >= (int'(t) << 7);
    endfunction

    // one sample on both channels, outputs checked one cycle later
    task automatic send;
        @(posedge clk_sys);
        in_valid <= 2'b11;
        in_i <= si;
        in_q <= sq;
        @(posedge clk_sys);
        in_valid <= 2'b00;
        #1;
        for (int c = 0; c < 2; c++) begin
            chk("out_valid", 32'h1, {31'h0, out_valid[c]});
            chk("out_i", {16'h0, gained(si[c], gain)}, {16'h0, out_i[c]});
            chk("out_q", {16'h0, gained(sq[c], gain)}, {16'h0, out_q[c]});
            chk("ctrl_i", {31'h0, over(gained(si[c], gain), thr_i)}, {31'h0, out_ctrl[c].i_over});
            chk("ctrl_q", {31'h0, over(gained(sq[c], gain), thr_q)}, {31'h0, out_ctrl[c].q_over});
        end
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        {srst, ce, psel, penable, pwrite} = 5'b11000;
        {paddr, pwdata, in_valid, in_i, in_q, si, sq, gain} = '0;
        {miscompares, checked} = '0;
        v = $urandom(32'h29c074e0);
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, addrs[k], 32'h0);
            chk("reset_value", {24'h0, rstv[k]}, rd);
            chk("mapped_err", 32'h0, {31'h0, err});
        end
        for (int k = 0; k < 4; k++) begin
            v = $urandom;
            apb(1'b1, addrs[k], v);
            apb(1'b0, addrs[k], 32'h0);
            chk("readback", {24'h0, v[7:0] & msk[k]}, rd);
        end
        apb(1'b0, 12'h850, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        apb(1'b0, 12'h842, 32'h0);
        chk("misaligned_err", 32'h1, {31'h0, err});
        // random samples with thresholds at, and one below, the level
        apb(1'b1, 12'h84c, 32'h0);
        for (int k = 0; k < 60; k++) begin
            if (k % 10 == 0) begin
                thr_i = 8'($urandom);
                thr_q = 8'($urandom);
                gain = 1'($urandom);
                apb(1'b1, 12'h840, {31'h0, gain});
                apb(1'b1, 12'h844, {24'h0, thr_i});
                apb(1'b1, 12'h848, {24'h0, thr_q});
            end
            for (int c = 0; c < 2; c++) begin
                si[c] = gain ? 16'($signed(16'($urandom)) >>> 1) : 16'($urandom);
                sq[c] = gain ? 16'($signed(16'($urandom)) >>> 1) : 16'($urandom);
            end
            if (k % 3 != 2) begin
                si[0] = 16'(({thr_i, 7'h0} >> gain) - 15'(k % 3));
            end
            send();
            chk("pins_disabled", 32'h0, {28'h0, pins});
        end
        // stretch length for exponent 0 and 3
        {thr_i, thr_q, gain} = {8'h80, 8'h80, 1'b0};
        apb(1'b1, 12'h840, 32'h0);
        apb(1'b1, 12'h844, 32'h80);
        apb(1'b1, 12'h848, 32'h80);
        for (int n = 0; n < 4; n += 3) begin
            apb(1'b1, 12'h84c, 32'h8 | n);
            {si, sq} = '0;
            si[0] = 16'h4000;
            send();
            repeat (80) @(posedge clk_sys);
            chk("width_a_i", 32'h8 << n, {16'h0, width[0]});
        end
        // a second detection two cycles later restarts the count
        apb(1'b1, 12'h84c, 32'h8);
        {si, sq} = '0;
        sq[1] = 16'hc000;
        send();
        send();
        repeat (30) @(posedge clk_sys);
        chk("width_b_q", 32'ha, {16'h0, width[3]});
        // a frozen block holds the pin pulse, so it lasts four cycles longer
        {si, sq} = '0;
        si[0] = 16'h4000;
        send();
        @(posedge clk_sys);
        ce <= 1'b0;
        #1;
        chk("ready_frozen", 32'h0, {31'h0, pready});
        repeat (4) @(posedge clk_sys);
        ce <= 1'b1;
        repeat (30) @(posedge clk_sys);
        chk("width_frozen", 32'hc, {16'h0, width[0]});
        // enable low keeps pins low while control bits still flag
        apb(1'b1, 12'h84c, 32'h0);
        {si, sq} = '0;
        si[1] = 16'h4000;
        send();
        repeat (20) @(posedge clk_sys);
        chk("pulses_b_i", 32'h0, {24'h0, pulses[2]});
        // interrupt masked, unmasked and cleared
        apb(1'b1, 12'h860, 32'hf);
        apb(1'b1, 12'h864, 32'h0);
        {si, sq} = '0;
        si[0] = 16'h4000;
        send();
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h860, 32'h0);
        chk("status", 32'h1, rd);
        apb(1'b1, 12'h864, 32'h1);
        #1;
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, 12'h860, 32'h1);
        #1;
        chk("irq_cleared", 32'h0, {31'h0, irq});
        stop_test();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end
endmodule
